// >>> common/fifo_ptr_consts.svh
// Offsets, field positions, reset values and counts of the FIFO pointer block.
`ifndef FIFO_PTR_CONSTS_SVH
`define FIFO_PTR_CONSTS_SVH
// Per-FIFO register bases, the CAN control register address and stride, byte addresses on the bus.
`define FIFO_CFG_BASE 12'h000
`define FIFO_UA_BASE 12'h100
`define FIFO_CI_BASE 12'h200
`define CAN_CON_ADDR 12'h300
`define FIFO_STRIDE_BITS 2
// Per-FIFO configuration word layout.
`define CFG_BASE_LSB 0
`define CFG_BASE_MSB 31
`define CFG_BASE_MASK 32'hffff_fffc
// Control word field positions.
`define CFG_SIZE_LSB 16
`define CFG_SIZE_MSB 20
`define CFG_POINTER_ADVANCE_BIT 13
`define CFG_FIFO_DIRECTION_TX_BIT 7
`define CON_OPERATING_MODE_SELECT_LSB 21
`define CON_OPERATING_MODE_SELECT_MSB 23
`define OPERATING_MODE_SELECT_CONFIG 3'h4
`define OPERATING_MODE_SELECT_RESET 3'h4
`define MSG_BYTES_DEFAULT 16
`endif

// >>> common/fifo_ptr_pkg.sv
// Types shared by the FIFO pointer status block.
package fifo_ptr_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01
   } bus_state_t;
endpackage

// >>> dv/can_engine_model.sv
// Behavioural CAN engine that reports finished messages per FIFO.
`timescale 1ns/1ps
module can_engine_model #(
   parameter int N = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic [N-1:0] msg_done
);
   initial msg_done = '0;
   // One pulse per message with a gap, since the block counts pulses.
   task automatic send(input int f, input int n);
      wait (hresetn === 1'b1);
      repeat (n) begin
         @(posedge hclk);
         msg_done <= N'(1) << f;
         @(posedge hclk);
         msg_done <= '0;
      end
   endtask
endmodule // can_engine_model

// >>> dv/can_fifo_pointer_status_props.sv
// Checker on the bus and mode ports of the FIFO pointer block.
`timescale 1ns/1ps
module can_fifo_pointer_status_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic config_mode
);
   // ---
   // Data phase decode
   // ---
   logic t;
   logic [3:0] k_q;
   assign t = hsel & hready & htrans[1];
   // Kind of taken transfer: mode write, address, index, unmapped read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         k_q <= 4'h0;
      end else begin
         k_q <= {t & hwrite & (haddr[11:0] == 12'h300),
            t & !hwrite & (haddr[11:8] == 4'h1),
            t & !hwrite & (haddr[11:8] == 4'h2),
            t & !hwrite & (haddr[11:10] != 2'b00)};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_enter; k_q[3] && hwdata[23:21] == 3'h4; endsequence
   sequence s_leave; k_q[3] && hwdata[23:21] != 3'h4; endsequence
   property p_enter; s_enter |-> ##[1:2] config_mode; endproperty
   property p_leave; s_leave |-> ##[1:2] !config_mode; endproperty
   property p_hold;
      $changed(config_mode) |-> $past(k_q[3]) || $past(k_q[3], 2);
   endproperty
   property p_align; k_q[2] |-> hrdata[1:0] == 2'b00; endproperty
   property p_upper; k_q[1] |-> hrdata[31:5] == 27'h0; endproperty
   property p_unmap; k_q[0] |-> hrdata == 32'h0; endproperty
   property p_wait; hreadyout; endproperty
   property p_okay; !hresp; endproperty
   a_enter: assert property (p_enter)
      else $error("mode 100 unflagged");
   a_leave: assert property (p_leave)
      else $error("mode flag stuck");
   a_hold: assert property (p_hold)
      else $error("mode flag moved");
   a_align: assert property (p_align)
      else $error("address unaligned");
   a_upper: assert property (p_upper)
      else $error("index upper bits");
   a_unmap: assert property (p_unmap) else $error("unmapped not zero");
   a_wait: assert property (p_wait) else $error("wait state seen");
   a_okay: assert property (p_okay) else $error("error response");
endmodule // can_fifo_pointer_status_props
bind can_fifo_pointer_status can_fifo_pointer_status_props i_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .config_mode(config_mode));

// >>> dv/can_fifo_pointer_status_tb.sv
// Self-checking bench for the FIFO pointer status block.
`timescale 1ns/1ps
module can_fifo_pointer_status_tb;
   localparam int MB = 16;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'b00;
   logic hreadyout, hresp, config_mode;
   logic [3:0] msg_done;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   always #12.5 hclk = ~hclk;
   can_engine_model #(.N(4)) i_eng (.hclk(hclk), .hresetn(hresetn),
      .msg_done(msg_done));
   can_fifo_pointer_status #(.NUM_FIFOS(4), .MSG_BYTES(MB)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .msg_done(msg_done), .config_mode(config_mode));
   // One single transfer; the answer is awaited, never assumed.
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic check(input string n, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic rd(input logic [31:0] a, input string n,
                     input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(n, q, e);
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // A hang costs a mismatch rather than an endless run.
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("cfg", {31'h0, config_mode}, 32'h1);
      rd(32'h200, "ci0 rst", 32'h0);
      xfer(32'h300, 1'b1, 32'h0080_0000);
      xfer(32'h000, 1'b1, 32'h0002_0080);
      xfer(32'h004, 1'b1, 32'h0001_0000);
      xfer(32'h100, 1'b1, 32'h1000_0003);
      xfer(32'h104, 1'b1, 32'h2000_0000);
      rd(32'h000, "dir0", 32'h0002_0080);
      rd(32'h004, "dir1", 32'h0001_0000);
      xfer(32'h300, 1'b1, 32'h0);
      rd(32'h300, "mode", 32'h0);
      check("cfg", {31'h0, config_mode}, 32'h0);
      rd(32'h100, "ua0", 32'h1000_0000);
      xfer(32'h000, 1'b1, 32'h0000_2080);
      rd(32'h100, "ua0 next",
         32'h1000_0000 + 32'(MB));
      xfer(32'h004, 1'b1, 32'h0000_2000);
      rd(32'h104, "ua1 next", 32'h2000_0000 + 32'(MB));
      i_eng.send(0, 4);
      rd(32'h200, "ci0 wrap", 32'h1);
      i_eng.send(1, 3);
      rd(32'h204, "ci1 wrap", 32'h1);
      rd(32'h400, "unmapped", 32'h0);
      end_of_test();
   end
endmodule // can_fifo_pointer_status_tb

// >>> rtl/can_fifo_pointer_status.sv
// FIFO pointer status registers with an AHB-Lite slave port.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "fifo_ptr_consts.svh"

module can_fifo_pointer_status
   import fifo_ptr_pkg::*;
#(
   parameter int NUM_FIFOS = 32,
   parameter int MSG_BYTES = `MSG_BYTES_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NUM_FIFOS-1:0] msg_done,
   output logic config_mode
);
   localparam int FW = $clog2(NUM_FIFOS);
   localparam logic [31:0] MSG_STEP = 32'(MSG_BYTES);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      bus_state_t bst;
      logic wr;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic [2:0] operating_mode_select;
      logic cfgm;
      logic [NUM_FIFOS-1:0] dir_tx;
      logic [NUM_FIFOS-1:0][4:0] depth_m1;
      logic [NUM_FIFOS-1:0][31:0] base;
      logic [NUM_FIFOS-1:0][4:0] user_idx;
   } top_state_t;
   top_state_t st_reg;
   top_state_t st_next;

   logic [NUM_FIFOS-1:0][4:0] ctrl_idx;
   logic [NUM_FIFOS-1:0] idx_clear;

   // ------------------------------------------------------------
   // Controller-side index counters
   // ------------------------------------------------------------
   // Each counter steps when the engine finishes a message of its FIFO.
   for (genvar g = 0; g < NUM_FIFOS; g++) begin : g_cnt
      fifo_slot_counter u_cnt (
         .hclk(hclk),
         .hresetn(hresetn),
         .clear(idx_clear[g]),
         .step(msg_done[g]),
         .depth_m1(st_reg.depth_m1[g]),
         .index(ctrl_idx[g])
      );
   end

   // Address of the user slot, kept aligned.
   function automatic logic [31:0] ua_value(input logic [31:0] b,
                                            input logic [4:0] i);
      logic [31:0] a;
      a = b + (32'(i) * MSG_STEP);
      return {a[31:2], 2'b00};
   endfunction

   // ------------------------------------------------------------
   // Bus and register logic
   // ------------------------------------------------------------
   // Reads are answered with zero wait states; the data phase always
   // completes in one cycle so hreadyout stays high.
   always_comb begin
      logic [FW-1:0] sel;
      logic [FW-1:0] wsel;
      logic [11:0] wa;
      logic [31:0] rd;
      sel = '0;
      wsel = '0;
      wa = '0;
      rd = '0;
      st_next = st_reg;
      idx_clear = '0;
      // Data phase of a write.
      if (st_reg.bst == ST_DATA && st_reg.wr) begin
         wa = st_reg.addr;
         wsel = FW'(wa[`FIFO_STRIDE_BITS +: 8]);
         if (wa[11:8] == `FIFO_CFG_BASE >> 8) begin
            // Direction and depth only change in configuration mode.
            if (st_reg.cfgm) begin
               st_next.dir_tx[wsel] = hwdata[`CFG_FIFO_DIRECTION_TX_BIT];
               st_next.depth_m1[wsel] = hwdata[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
               st_next.user_idx[wsel] = 5'h00;
               idx_clear[wsel] = 1'b1;
            end
            if (hwdata[`CFG_POINTER_ADVANCE_BIT] && !st_reg.cfgm) begin
               // Head for transmit, tail for receive: same user pointer.
               if (st_reg.user_idx[wsel] >= st_reg.depth_m1[wsel]) begin
                  st_next.user_idx[wsel] = 5'h00;
               end else begin
                  st_next.user_idx[wsel] = st_reg.user_idx[wsel] + 5'h01;
               end
            end
         end else if (wa[11:8] == `FIFO_UA_BASE >> 8) begin
            // Writes to the user address space set the slot base, in configuration mode only.
            if (st_reg.cfgm) begin
               st_next.base[wsel] = hwdata & `CFG_BASE_MASK;
            end
         end else if (wa == `CAN_CON_ADDR) begin
            st_next.operating_mode_select = hwdata[`CON_OPERATING_MODE_SELECT_MSB:`CON_OPERATING_MODE_SELECT_LSB];
         end
      end
      st_next.cfgm = (st_next.operating_mode_select == `OPERATING_MODE_SELECT_CONFIG);
      // Address phase.
      st_next.bst = ST_IDLE;
      st_next.wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         st_next.bst = ST_DATA;
         st_next.wr = hwrite;
         st_next.addr = haddr[11:0];
         sel = FW'(haddr[`FIFO_STRIDE_BITS +: 8]);
         if (!hwrite) begin
            if (haddr[11:8] == `FIFO_CFG_BASE >> 8) begin
               rd[`CFG_FIFO_DIRECTION_TX_BIT] = st_reg.dir_tx[sel];
               rd[`CFG_SIZE_MSB:`CFG_SIZE_LSB] = st_reg.depth_m1[sel];
            end else if (haddr[11:8] == `FIFO_UA_BASE >> 8) begin
               // Valid only outside configuration mode.
               rd = ua_value(st_reg.base[sel],
                             st_reg.user_idx[sel]);
            end else if (haddr[11:8] == `FIFO_CI_BASE >> 8) begin
               rd = {27'h0000000, ctrl_idx[sel]};
            end else if (haddr[11:0] == `CAN_CON_ADDR) begin
               rd[`CON_OPERATING_MODE_SELECT_MSB:`CON_OPERATING_MODE_SELECT_LSB] = st_reg.operating_mode_select;
            end
            st_next.rdata = rd;
         end
      end
   end

   // Register the whole block state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.operating_mode_select <= `OPERATING_MODE_SELECT_RESET;
         st_reg.cfgm <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // hrdata and config_mode come straight from flip-flops; hreadyout is tied high and response is always OKAY.
   assign hrdata = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign config_mode = st_reg.cfgm;
endmodule // can_fifo_pointer_status

// >>> rtl/fifo_slot_counter.sv
// One FIFO slot index counter that wraps at the configured depth.
`timescale 1ns/1ps
module fifo_slot_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   input wire logic step,
   input wire logic [4:0] depth_m1,
   output logic [4:0] index
);
   typedef struct packed {
      logic [4:0] idx;
   } cnt_state_t;
   cnt_state_t st_reg;
   cnt_state_t st_next;

   // Step by one slot and wrap back to zero past the last slot.
   always_comb begin
      st_next = st_reg;
      if (clear) begin
         st_next.idx = 5'h00;
      end else if (step) begin
         if (st_reg.idx >= depth_m1) begin
            st_next.idx = 5'h00;
         end else begin
            st_next.idx = st_reg.idx + 5'h01;
         end
      end
   end

   // Register the counter state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign index = st_reg.idx;
endmodule // fifo_slot_counter
